/* core/efr_cfg.svh */
// Register offsets, field positions and reset values of the egress frame rewriter.
`ifndef EFR_CFG_SVH
`define EFR_CFG_SVH
`define EFR_ADDR_W 10
`define EFR_OFS_DP1_TABLE 10'h000
`define EFR_OFS_REMAP_TABLE 10'h100
`define EFR_OFS_TAG_SELECT 10'h204
`define EFR_OFS_PORT_CTRL 10'h208
`define EFR_OFS_DSCP_CTRL 10'h20C
`define EFR_OFS_PRIO_MAP 10'h210
`define EFR_OFS_PTP_CTRL 10'h250
`define EFR_OFS_ASYM_DELAY 10'h254
`define EFR_OFS_STATUS 10'h258
`define EFR_FLD_AGEING_DISABLE 0
`define EFR_FLD_DISCARD 1
`define EFR_FLD_CSUM_CPU 2
`define EFR_FLD_CSUM_NET_LO 3
`define EFR_FLD_TWOSTEP_DIS 1
`define EFR_FLD_ONESTEP_DIS 2
`define EFR_FLD_MAP_DEI 3
`define EFR_FLD_DELAY_ENA_BIT 5
`define EFR_RST_PORT_CTRL 6'h04
`define EFR_FIFO_DEPTH 4
`endif

/* core/efr_pkg.sv */
// Types shared by the egress frame rewriter.
package efr_pkg;
  typedef enum logic [1:0] {
    EFR_CSUM_IF_CHANGED = 2'h0,
    EFR_CSUM_NEVER = 2'h1,
    EFR_CSUM_ALWAYS = 2'h2,
    EFR_CSUM_RESERVED = 2'h3
  } efr_csum_t;
  typedef enum logic [1:0] {
    EFR_DSCP_KEEP = 2'h0,
    EFR_DSCP_DIRECT = 2'h1,
    EFR_DSCP_REMAP = 2'h2,
    EFR_DSCP_REMAP_DP = 2'h3
  } efr_dscp_mode_t;
  typedef enum logic [1:0] {
    EFR_TAG_CLASSIFIED = 2'h0,
    EFR_TAG_PORT_DEFAULT = 2'h1,
    EFR_TAG_MAPPED = 2'h2,
    EFR_TAG_QOS_OR_DP = 2'h3
  } efr_tag_sel_t;
  typedef enum logic [1:0] {
    EFR_PTP_NONE = 2'h0,
    EFR_PTP_ONESTEP = 2'h1,
    EFR_PTP_TWOSTEP = 2'h2,
    EFR_PTP_ORIGIN = 2'h3
  } efr_ptp_cmd_t;
  typedef struct packed {
    logic fcs_recompute;
    logic no_ageing;
    logic dscp_write;
    logic [5:0] dscp;
    logic [2:0] pcp;
    logic dei;
    logic onestep_update;
    logic origin_update;
    logic twostep_store;
    logic [31:0] residence;
  } efr_desc_t;
endpackage

/* core/efr_rewriter.sv */
// Egress frame rewriter: per-frame decision logic, register file and output FIFO.
//
// Behaviour
// - Network frames: checksum policy 0 changed, 1 never, 2 always.
// - Injected frames recompute checksum when bit set; resets one.
// - Discard bit drops every frame to this port.
// - Ageing-disable bit stops ageing of queued frames.
// - DSCP mode 0 keeps, mode 1 writes analyzer value.
// - DSCP mode 2 remaps through general table.
// - Mode 3, precedence 1 uses dedicated table.
// - Mode 3, precedence 0 uses general table.
// - Two shared 64-entry six-bit tables, reset zero.
// - PCP from entry eight times precedence plus class.
// - DEI bit from that same entry.
// - Mapped values used only when selection chooses mapping.
// - Selection: 0 classified, 1 default, 2 map, 3 class/precedence.
// - One-step disable ignores one-step and origin commands.
// - Two-step disable suppresses departure time storage.
// - Delay-enable op bit adds signed delay to residence of one-step frames.
`timescale 1ns/1ps
`include "efr_cfg.svh"

module efr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  output logic [$clog2(DEPTH):0] level_out
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [PW:0] count;
  } efr_fifo_state_t;
  efr_fifo_state_t s_q;
  efr_fifo_state_t s_d;
  logic push;
  logic pop;

  if (WIDTH < 1) begin
    $error("efr_fifo: WIDTH must be at least 1");
  end
  if (DEPTH < 2 || (1 << PW) != DEPTH) begin
    $error("efr_fifo: DEPTH must be a power of two of at least 2");
  end

  // Full and empty come straight from the count so the source really stalls.
  assign in_ready_out = (s_q.count != (PW + 1)'(DEPTH));
  assign out_valid_out = (s_q.count != '0);
  assign out_data_out = s_q.mem[s_q.rptr];
  assign level_out = s_q.count;
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  // Pointers wrap by themselves because the depth is a power of two.
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wptr] = in_data_in;
      s_d.wptr = s_q.wptr + PW'(1);
    end
    if (pop) begin
      s_d.rptr = s_q.rptr + PW'(1);
    end
    s_d.count = s_q.count + (PW + 1)'(push) - (PW + 1)'(pop);
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

module efr_rewriter #(
  parameter int FIFO_DEPTH = `EFR_FIFO_DEPTH
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [`EFR_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic frm_valid_in,
  output logic frm_ready_out,
  input wire logic frm_from_cpu_in,
  input wire logic frm_data_changed_in,
  input wire logic [5:0] frm_ana_dscp_in,
  input wire logic frm_drop_precedence_in,
  input wire logic [2:0] frm_qos_class_in,
  input wire logic [2:0] frm_cls_pcp_in,
  input wire logic frm_cls_dei_in,
  input wire logic [1:0] frm_ptp_cmd_in,
  input wire logic [5:0] frm_rewrite_operation_code_in,
  input wire logic [31:0] frm_residence_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic out_fcs_recompute_out,
  output logic out_no_ageing_out,
  output logic out_dscp_write_out,
  output logic [5:0] out_dscp_out,
  output logic [2:0] out_pcp_out,
  output logic out_dei_out,
  output logic out_onestep_update_out,
  output logic out_origin_update_out,
  output logic out_twostep_store_out,
  output logic [31:0] out_residence_out
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  typedef struct packed {
    logic [63:0][5:0] dp1_table;
    logic [63:0][5:0] remap_table;
    logic [15:0][3:0] prio_map;
    logic [1:0] tag_priority_select;
    logic [1:0] tag_eligibility_select;
    logic [2:0] port_pcp;
    logic port_dei;
    logic [5:0] port_ctrl;
    logic [1:0] codepoint_rewrite_mode;
    logic onestep_time_disable;
    logic twostep_time_disable;
    logic [31:0] asymmetric_delay_value;
    logic [15:0] discard_count;
    logic ack;
    logic [31:0] rdata;
  } efr_state_t;

  efr_state_t s_q;
  efr_state_t s_d;
  logic rst_meta_q;
  logic rst_sync_q;
  efr_pkg::efr_desc_t desc;
  efr_pkg::efr_desc_t fifo_out;
  logic fifo_in_ready;
  logic [LW-1:0] fifo_level;
  logic push;
  logic access;
  logic [5:0] word;
  logic [3:0] map_idx;
  logic [3:0] map_entry;
  logic csum_changed;
  logic onestep_req;

  // The status word reports the queue level in sixteen bits.
  if (FIFO_DEPTH > 32768) begin
    $error("efr_rewriter: FIFO_DEPTH does not fit the status word");
  end
  if (FIFO_DEPTH < 2) begin
    $error("efr_rewriter: FIFO_DEPTH must be at least 2");
  end

  // Reset is released through two flops so every register leaves reset on the same edge.
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign access = avs_read_in | avs_write_in;
  // The low two address bits are ignored for the tables; control registers decode the full address.
  assign word = avs_address_in[7:2];
  // One wait cycle per access; the answer stands on the second edge.
  assign avs_waitrequest_out = access & ~s_q.ack;
  assign avs_readdata_out = s_q.rdata;

  // Per-frame decision, computed as the frame descriptor is taken.
  always_comb begin
    desc = '0;
    desc.no_ageing = s_q.port_ctrl[`EFR_FLD_AGEING_DISABLE];
    case (efr_pkg::efr_dscp_mode_t'(s_q.codepoint_rewrite_mode))
      efr_pkg::EFR_DSCP_KEEP: begin
        desc.dscp_write = 1'b0;
        desc.dscp = frm_ana_dscp_in;
      end
      efr_pkg::EFR_DSCP_DIRECT: begin
        desc.dscp_write = 1'b1;
        desc.dscp = frm_ana_dscp_in;
      end
      efr_pkg::EFR_DSCP_REMAP: begin
        desc.dscp_write = 1'b1;
        desc.dscp = s_q.remap_table[frm_ana_dscp_in];
      end
      efr_pkg::EFR_DSCP_REMAP_DP: begin
        desc.dscp_write = 1'b1;
        desc.dscp = frm_drop_precedence_in ? s_q.dp1_table[frm_ana_dscp_in] : s_q.remap_table[frm_ana_dscp_in];
      end
      default: begin
        desc.dscp_write = 1'b0;
        desc.dscp = frm_ana_dscp_in;
      end
    endcase
    // A rewritten codepoint alters the frame, so the checksum treats it as a change.
    csum_changed = frm_data_changed_in | desc.dscp_write;
    if (frm_from_cpu_in) begin
      desc.fcs_recompute = s_q.port_ctrl[`EFR_FLD_CSUM_CPU];
    end else begin
      case (efr_pkg::efr_csum_t'(s_q.port_ctrl[`EFR_FLD_CSUM_NET_LO +: 2]))
        efr_pkg::EFR_CSUM_IF_CHANGED: desc.fcs_recompute = csum_changed;
        efr_pkg::EFR_CSUM_NEVER: desc.fcs_recompute = 1'b0;
        efr_pkg::EFR_CSUM_ALWAYS: desc.fcs_recompute = 1'b1;
        default: desc.fcs_recompute = csum_changed;
      endcase
    end
    // Concatenation gives eight times precedence plus class with no multiplier.
    // Entry eight times precedence plus class
    map_idx = {frm_drop_precedence_in, frm_qos_class_in};
    map_entry = s_q.prio_map[map_idx];
    case (efr_pkg::efr_tag_sel_t'(s_q.tag_priority_select))
      efr_pkg::EFR_TAG_CLASSIFIED: desc.pcp = frm_cls_pcp_in;
      efr_pkg::EFR_TAG_PORT_DEFAULT: desc.pcp = s_q.port_pcp;
      efr_pkg::EFR_TAG_MAPPED: desc.pcp = map_entry[2:0];
      default: desc.pcp = frm_qos_class_in;
    endcase
    case (efr_pkg::efr_tag_sel_t'(s_q.tag_eligibility_select))
      efr_pkg::EFR_TAG_CLASSIFIED: desc.dei = frm_cls_dei_in;
      efr_pkg::EFR_TAG_PORT_DEFAULT: desc.dei = s_q.port_dei;
      efr_pkg::EFR_TAG_MAPPED: desc.dei = map_entry[`EFR_FLD_MAP_DEI];
      default: desc.dei = frm_drop_precedence_in;
    endcase
    onestep_req = (frm_ptp_cmd_in == efr_pkg::EFR_PTP_ONESTEP) & ~s_q.onestep_time_disable;
    desc.onestep_update = onestep_req;
    desc.origin_update = (frm_ptp_cmd_in == efr_pkg::EFR_PTP_ORIGIN) & ~s_q.onestep_time_disable;
    desc.twostep_store = (frm_ptp_cmd_in == efr_pkg::EFR_PTP_TWOSTEP) & ~s_q.twostep_time_disable;
    // Origin commands never take the delay; only one-step frames have it added to residence.
    // Asymmetric delay add
    if (onestep_req && frm_rewrite_operation_code_in[`EFR_FLD_DELAY_ENA_BIT]) begin
      desc.residence = frm_residence_in + s_q.asymmetric_delay_value;
    end else begin
      desc.residence = frm_residence_in;
    end
  end

  // Nothing is taken until reset is released, since a queue held in reset would lose it.
  // Discarded frames are taken but never queued
  assign frm_ready_out = rst_sync_q & (s_q.port_ctrl[`EFR_FLD_DISCARD] | fifo_in_ready);
  assign push = rst_sync_q & frm_valid_in & ~s_q.port_ctrl[`EFR_FLD_DISCARD];

  // The queue lets the decision run ahead of a stalled receiver and keeps frame order.
  efr_fifo #(
    .WIDTH($bits(efr_pkg::efr_desc_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock_in(clock_in),
    .rst_n_in(rst_sync_q),
    .in_valid_in(push),
    .in_ready_out(fifo_in_ready),
    .in_data_in(desc),
    .out_valid_out(out_valid_out),
    .out_ready_in(out_ready_in),
    .out_data_out(fifo_out),
    .level_out(fifo_level)
  );

  assign out_fcs_recompute_out = fifo_out.fcs_recompute;
  assign out_no_ageing_out = fifo_out.no_ageing;
  assign out_dscp_write_out = fifo_out.dscp_write;
  assign out_dscp_out = fifo_out.dscp;
  assign out_pcp_out = fifo_out.pcp;
  assign out_dei_out = fifo_out.dei;
  assign out_onestep_update_out = fifo_out.onestep_update;
  assign out_origin_update_out = fifo_out.origin_update;
  assign out_twostep_store_out = fifo_out.twostep_store;
  assign out_residence_out = fifo_out.residence;

  // Register file. Byte enable 0 gates every table and control write; the delay word uses all four lanes.
  always_comb begin
    s_d = s_q;
    s_d.ack = access & ~s_q.ack;
    // The discard tally wraps; software reads it as a free-running count.
    if (frm_valid_in && s_q.port_ctrl[`EFR_FLD_DISCARD]) begin
      s_d.discard_count = s_q.discard_count + 16'h0001;
    end
    if (avs_read_in && !s_q.ack) begin
      s_d.rdata = 32'h00000000;
      if (avs_address_in[9:8] == 2'h0) begin
        s_d.rdata = {26'h0000000, s_q.dp1_table[word]};
      end else if (avs_address_in[9:8] == 2'h1) begin
        s_d.rdata = {26'h0000000, s_q.remap_table[word]};
      end else if (avs_address_in >= `EFR_OFS_PRIO_MAP && avs_address_in < `EFR_OFS_PTP_CTRL) begin
        s_d.rdata = {28'h0000000, s_q.prio_map[word[3:0] - 4'h4]};
      end else begin
        case (avs_address_in)
          `EFR_OFS_TAG_SELECT: s_d.rdata = {24'h000000, s_q.port_dei, s_q.port_pcp,
                                            s_q.tag_priority_select, s_q.tag_eligibility_select};
          `EFR_OFS_PORT_CTRL: s_d.rdata = {26'h0000000, s_q.port_ctrl};
          `EFR_OFS_DSCP_CTRL: s_d.rdata = {30'h00000000, s_q.codepoint_rewrite_mode};
          `EFR_OFS_PTP_CTRL: s_d.rdata = {29'h00000000, s_q.onestep_time_disable,
                                          s_q.twostep_time_disable, 1'b0};
          `EFR_OFS_ASYM_DELAY: s_d.rdata = s_q.asymmetric_delay_value;
          `EFR_OFS_STATUS: s_d.rdata = {s_q.discard_count, 16'(fifo_level)};
          default: s_d.rdata = 32'h00000000;
        endcase
      end
    end
    if (avs_write_in && s_q.ack && avs_byteenable_in[0]) begin
      if (avs_address_in[9:8] == 2'h0) begin
        s_d.dp1_table[word] = avs_writedata_in[5:0];
      end else if (avs_address_in[9:8] == 2'h1) begin
        s_d.remap_table[word] = avs_writedata_in[5:0];
      end else if (avs_address_in >= `EFR_OFS_PRIO_MAP && avs_address_in < `EFR_OFS_PTP_CTRL) begin
        s_d.prio_map[word[3:0] - 4'h4] = avs_writedata_in[3:0];
      end else begin
        case (avs_address_in)
          `EFR_OFS_TAG_SELECT: begin
            s_d.tag_eligibility_select = avs_writedata_in[1:0];
            s_d.tag_priority_select = avs_writedata_in[3:2];
            s_d.port_pcp = avs_writedata_in[6:4];
            s_d.port_dei = avs_writedata_in[7];
          end
          `EFR_OFS_PORT_CTRL: s_d.port_ctrl = avs_writedata_in[5:0];
          `EFR_OFS_DSCP_CTRL: s_d.codepoint_rewrite_mode = avs_writedata_in[1:0];
          `EFR_OFS_PTP_CTRL: begin
            s_d.twostep_time_disable = avs_writedata_in[`EFR_FLD_TWOSTEP_DIS];
            s_d.onestep_time_disable = avs_writedata_in[`EFR_FLD_ONESTEP_DIS];
          end
          default: s_d.rdata = s_q.rdata;
        endcase
      end
    end
    // Byte lanes let software change the signed delay one byte at a time.
    if (avs_write_in && s_q.ack && avs_address_in == `EFR_OFS_ASYM_DELAY) begin
      for (int b = 0; b < 4; b++) begin
        if (avs_byteenable_in[b]) begin
          s_d.asymmetric_delay_value[b*8 +: 8] = avs_writedata_in[b*8 +: 8];
        end
      end
    end
  end

  // Injected-frame checksum bit resets to one
  always_ff @(posedge clock_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      s_q <= '0;
      s_q.port_ctrl <= `EFR_RST_PORT_CTRL;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

/* dv/efr_rewriter_chk.sv */
// Port checker of the egress frame rewriter, with a shadow of its configuration words.
`timescale 1ns/1ps
`include "efr_cfg.svh"
module efr_rewriter_chk #(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [`EFR_ADDR_W-1:0] avs_address_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic avs_waitrequest_out,
  input wire logic frm_valid_in,
  input wire logic frm_ready_out,
  input wire logic frm_from_cpu_in,
  input wire logic frm_data_changed_in,
  input wire logic [5:0] frm_ana_dscp_in,
  input wire logic [1:0] frm_ptp_cmd_in,
  input wire logic [5:0] frm_rewrite_operation_code_in,
  input wire logic [31:0] frm_residence_in,
  input wire logic out_valid_out,
  input wire logic out_fcs_recompute_out,
  input wire logic out_no_ageing_out,
  input wire logic out_dscp_write_out,
  input wire logic [5:0] out_dscp_out,
  input wire logic out_onestep_update_out,
  input wire logic out_origin_update_out,
  input wire logic out_twostep_store_out,
  input wire logic [31:0] out_residence_out
);
  typedef struct packed {logic [5:0] ctl; logic [1:0] mode; logic [2:0] ptp; logic [31:0] dly;} efr_shadow_t;
  efr_shadow_t s_q, s_d;
  logic net_fcs;
  logic [31:0] res_sum;
  // The shadow assumes full-word writes, which is all the bench issues.
  always_comb begin
    s_d = s_q;
    if (avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]) begin
      case (avs_address_in)
        `EFR_OFS_PORT_CTRL: s_d.ctl = avs_writedata_in[5:0];
        `EFR_OFS_DSCP_CTRL: s_d.mode = avs_writedata_in[1:0];
        `EFR_OFS_PTP_CTRL: s_d.ptp = avs_writedata_in[2:0];
        `EFR_OFS_ASYM_DELAY: s_d.dly = avs_writedata_in;
        default: ;
      endcase
    end
  end
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_q <= {`EFR_RST_PORT_CTRL, 37'h0};
    end else begin
      s_q <= s_d;
    end
  end
  assign net_fcs = s_q.ctl[4:3] == 2'h2 || (s_q.ctl[4:3] != 2'h1 && (frm_data_changed_in || s_q.mode != 2'h0));
  assign res_sum = frm_residence_in + s_q.dly;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  sequence take_s;
    frm_valid_in && frm_ready_out && !out_valid_out && !s_q.ctl[1];
  endsequence
  sequence drop_s;
    frm_valid_in && s_q.ctl[1] && !out_valid_out;
  endsequence
  discard_drop_a: assert property (drop_s |-> frm_ready_out ##1 !out_valid_out)
    else $error("Discarded frame reached the output.");
  csum_cpu_a: assert property (take_s ##0 frm_from_cpu_in |=> out_fcs_recompute_out == $past(s_q.ctl[2]))
    else $error("Injected frame checksum flag is wrong.");
  csum_net_a: assert property (take_s ##0 !frm_from_cpu_in |=> out_fcs_recompute_out == $past(net_fcs))
    else $error("Network frame checksum flag is wrong.");
  ageing_off_a: assert property (take_s |=> out_valid_out && out_no_ageing_out == $past(s_q.ctl[0]))
    else $error("Ageing flag does not follow the port setting.");
  dscp_flag_a: assert property (take_s |=> out_dscp_write_out == ($past(s_q.mode) != 2'h0))
    else $error("Codepoint write flag is wrong.");
  dscp_direct_a: assert property (take_s ##0 !s_q.mode[1] |=> out_dscp_out == $past(frm_ana_dscp_in))
    else $error("Codepoint is not the analyzer value.");
  onestep_gate_a: assert property (take_s ##0 frm_ptp_cmd_in[0] |=>
    out_onestep_update_out == ($past(frm_ptp_cmd_in) == 2'h1 && !$past(s_q.ptp[2])) &&
    out_origin_update_out == ($past(frm_ptp_cmd_in) == 2'h3 && !$past(s_q.ptp[2])))
    else $error("One-step command not gated.");
  twostep_gate_a: assert property (take_s ##0 frm_ptp_cmd_in == 2'h2 |=>
    out_twostep_store_out == !$past(s_q.ptp[1]))
    else $error("Two-step command not gated.");
  delay_add_a: assert property (take_s ##0 (frm_ptp_cmd_in == 2'h1 && !s_q.ptp[2] &&
    frm_rewrite_operation_code_in[5]) |=> out_residence_out == $past(res_sum))
    else $error("Asymmetric delay not added.");
endmodule
bind efr_rewriter efr_rewriter_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.*);

/* dv/efr_mac_model.sv */
// Egress port receiver model that takes descriptors promptly, slowly or not at all.
`timescale 1ns/1ps
module efr_mac_model (
  input wire logic clock_in,
  input wire logic stall_in,
  input wire logic slow_in,
  input wire logic vld_in,
  input wire efr_pkg::efr_desc_t d_in,
  output logic ready_out
);
  efr_pkg::efr_desc_t got[$];
  logic odd_q = 1'h0;
  // A slow receiver accepts only every other cycle, so the output must hold its entry.
  always_ff @(posedge clock_in) begin
    odd_q <= !odd_q;
    if (vld_in && ready_out) begin
      got.push_back(d_in);
    end
  end
  assign ready_out = !stall_in && !(slow_in && odd_q);
endmodule

/* dv/tb_top.sv */
// Self-checking testbench of the egress frame rewriter.
`timescale 1ns/1ps
`include "efr_cfg.svh"
module tb_top;
  typedef struct {logic [5:0] ctl; logic [1:0] mode; logic [2:0] ptp; logic [7:0] tag; logic cpu; logic chg;
    logic [5:0] ds; logic dp; logic [2:0] qos; logic [2:0] cpcp; logic cdei; logic [1:0] cmd; logic [5:0] op;
    logic [31:0] res;} efr_row_t;
  localparam logic [31:0] DLY_NS = 32'hFFFF_FFF6;
  logic clock_in, reset_n_in, avs_read_in, avs_write_in, avs_waitrequest_out, frm_valid_in, frm_ready_out;
  logic [`EFR_ADDR_W-1:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, frm_residence_in, out_residence_out;
  logic [3:0] avs_byteenable_in;
  logic frm_from_cpu_in, frm_data_changed_in, frm_drop_precedence_in, frm_cls_dei_in, out_valid_out, out_ready_in;
  logic [5:0] frm_ana_dscp_in, frm_rewrite_operation_code_in, out_dscp_out;
  logic [2:0] frm_qos_class_in, frm_cls_pcp_in, out_pcp_out;
  logic [1:0] frm_ptp_cmd_in;
  logic out_fcs_recompute_out, out_no_ageing_out, out_dscp_write_out, out_dei_out, mac_stall, mac_slow;
  logic out_onestep_update_out, out_origin_update_out, out_twostep_store_out;
  int n_errors = 0;
  int cmp_count = 0;
  efr_pkg::efr_desc_t d;
  efr_row_t rows[9] = '{
    '{6'h04, 2'h0, 3'h0, 8'h00, 1'h0, 1'h0, 6'h11, 1'h0, 3'h2, 3'h5, 1'h1, 2'h1, 6'h20, 32'h3E8},
    '{6'h04, 2'h0, 3'h4, 8'hD5, 1'h0, 1'h1, 6'h22, 1'h1, 3'h3, 3'h2, 1'h0, 2'h1, 6'h20, 32'h3E8},
    '{6'h0C, 2'h1, 3'h4, 8'h0A, 1'h0, 1'h1, 6'h3F, 1'h1, 3'h7, 3'h1, 1'h0, 2'h3, 6'h00, 32'h10},
    '{6'h14, 2'h2, 3'h0, 8'h0F, 1'h0, 1'h0, 6'h05, 1'h1, 3'h4, 3'h0, 1'h0, 2'h3, 6'h00, 32'h20},
    '{6'h1C, 2'h0, 3'h2, 8'h0A, 1'h0, 1'h0, 6'h2A, 1'h0, 3'h1, 3'h0, 1'h0, 2'h2, 6'h00, 32'h30},
    '{6'h1C, 2'h0, 3'h0, 8'h00, 1'h0, 1'h1, 6'h2A, 1'h0, 3'h1, 3'h0, 1'h0, 2'h2, 6'h00, 32'h40},
    '{6'h18, 2'h3, 3'h0, 8'h0A, 1'h1, 1'h0, 6'h07, 1'h1, 3'h6, 3'h0, 1'h0, 2'h1, 6'h1F, 32'h50},
    '{6'h05, 2'h3, 3'h6, 8'h05, 1'h1, 1'h0, 6'h30, 1'h0, 3'h0, 3'h7, 1'h1, 2'h0, 6'h20, 32'h60},
    '{6'h18, 2'h3, 3'h0, 8'h00, 1'h0, 1'h0, 6'h09, 1'h0, 3'h5, 3'h3, 1'h0, 2'h0, 6'h00, 32'h70}};
  efr_rewriter u_dut (.*);
  efr_mac_model u_mac (.clock_in(clock_in), .stall_in(mac_stall), .slow_in(mac_slow), .vld_in(out_valid_out),
    .d_in({out_fcs_recompute_out, out_no_ageing_out, out_dscp_write_out, out_dscp_out, out_pcp_out, out_dei_out,
    out_onestep_update_out, out_origin_update_out, out_twostep_store_out, out_residence_out}), .ready_out(out_ready_in));
  initial begin
    clock_in = 1'h0;
    forever #4 clock_in = !clock_in;
  end
  task chk(input logic [63:0] g, input logic [63:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task results();
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task do_reset();
    reset_n_in <= 1'h0;
    repeat (16) @(posedge clock_in);
    reset_n_in <= 1'h1;
    repeat (3) @(posedge clock_in);
  endtask
  // The request stands until waitrequest is seen low at an edge; one idle edge follows.
  task automatic bus(input logic [9:0] a, input logic w, input logic [31:0] wd, output logic [31:0] q);
    avs_address_in <= a;
    avs_writedata_in <= wd;
    avs_write_in <= w;
    avs_read_in <= !w;
    do begin
      @(posedge clock_in);
    end while (avs_waitrequest_out !== 1'h0);
    q = avs_readdata_out;
    avs_write_in <= 1'h0;
    avs_read_in <= 1'h0;
    @(posedge clock_in);
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] wd);
    logic [31:0] q;
    bus(a, 1'h1, wd, q);
  endtask
  task automatic rdc(input logic [9:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(a, 1'h0, 32'h0, q);
    chk(64'(q), 64'(e));
  endtask
  // Leaves valid high so that frames can follow back to back.
  task automatic send(efr_row_t r);
    {frm_from_cpu_in, frm_data_changed_in, frm_ana_dscp_in, frm_drop_precedence_in, frm_qos_class_in} <=
      {r.cpu, r.chg, r.ds, r.dp, r.qos};
    {frm_cls_pcp_in, frm_cls_dei_in, frm_ptp_cmd_in, frm_rewrite_operation_code_in, frm_residence_in} <=
      {r.cpcp, r.cdei, r.cmd, r.op, r.res};
    frm_valid_in <= 1'h1;
    do begin
      @(posedge clock_in);
    end while (frm_ready_out !== 1'h1);
  endtask
  task automatic get(output efr_pkg::efr_desc_t g);
    while (u_mac.got.size() == 0) begin
      @(posedge clock_in);
    end
    g = u_mac.got.pop_front();
  endtask
  function automatic efr_pkg::efr_desc_t exp_of(efr_row_t r);
    efr_pkg::efr_desc_t e;
    logic [3:0] m;
    logic [2:0] pc[4];
    logic dv[4];
    m = {r.dp, r.qos} ^ 4'h9;
    pc = '{r.cpcp, r.tag[6:4], m[2:0], r.qos};
    dv = '{r.cdei, r.tag[7], m[3], r.dp};
    e.fcs_recompute = r.cpu ? r.ctl[2] : (r.ctl[4:3] == 2'h2 || (r.ctl[4:3] != 2'h1 && (r.chg || r.mode != 2'h0)));
    e.no_ageing = r.ctl[0];
    e.dscp_write = r.mode != 2'h0;
    e.dscp = !r.mode[1] ? r.ds : (r.mode[0] && r.dp) ? ~r.ds : r.ds ^ 6'h15;
    e.pcp = pc[r.tag[3:2]];
    e.dei = dv[r.tag[1:0]];
    e.onestep_update = r.cmd == 2'h1 && !r.ptp[2];
    e.origin_update = r.cmd == 2'h3 && !r.ptp[2];
    e.twostep_store = r.cmd == 2'h2 && !r.ptp[1];
    e.residence = r.res + ((e.onestep_update && r.op[5]) ? DLY_NS : 32'h0);
    return e;
  endfunction
  initial begin
    #160000;
    n_errors++;
    results();
  end
  initial begin
    {avs_read_in, avs_write_in, avs_address_in, avs_writedata_in, frm_valid_in, mac_stall, mac_slow} = '0;
    {frm_from_cpu_in, frm_data_changed_in, frm_ana_dscp_in, frm_drop_precedence_in, frm_qos_class_in} = '0;
    {frm_cls_pcp_in, frm_cls_dei_in, frm_ptp_cmd_in, frm_rewrite_operation_code_in, frm_residence_in} = '0;
    avs_byteenable_in = 4'hF;
    reset_n_in = 1'h0;
    do_reset();
    for (int i = 0; i < 64; i++) begin
      wr(`EFR_OFS_DP1_TABLE + 10'(4 * i), 32'(~6'(i)));
      wr(`EFR_OFS_REMAP_TABLE + 10'(4 * i), 32'(6'(i) ^ 6'h15));
    end
    for (int i = 0; i < 16; i++) wr(`EFR_OFS_PRIO_MAP + 10'(4 * i), 32'(4'(i) ^ 4'h9));
    wr(`EFR_OFS_ASYM_DELAY, DLY_NS);
    mac_slow <= 1'h1;
    foreach (rows[i]) begin
      wr(`EFR_OFS_PORT_CTRL, 32'(rows[i].ctl));
      wr(`EFR_OFS_DSCP_CTRL, 32'(rows[i].mode));
      wr(`EFR_OFS_PTP_CTRL, 32'(rows[i].ptp));
      wr(`EFR_OFS_TAG_SELECT, 32'(rows[i].tag));
      send(rows[i]);
      frm_valid_in <= 1'h0;
      get(d);
      chk(64'(d), 64'(exp_of(rows[i])));
    end
    do_reset();
    rdc(`EFR_OFS_PORT_CTRL, 32'h4);
    rdc(`EFR_OFS_DP1_TABLE + 10'hFC, 32'h0);
    rdc(`EFR_OFS_REMAP_TABLE + 10'h84, 32'h0);
    wr(`EFR_OFS_REMAP_TABLE + 10'h84, 32'hFFFF_FFFF);
    rdc(`EFR_OFS_REMAP_TABLE + 10'h84, 32'h3F);
    rdc(`EFR_OFS_ASYM_DELAY, 32'h0);
    mac_stall <= 1'h1;
    mac_slow <= 1'h0;
    wr(`EFR_OFS_PORT_CTRL, 32'h6);
    for (int k = 0; k < 3; k++) send(rows[0]);
    frm_valid_in <= 1'h0;
    rdc(`EFR_OFS_STATUS, 32'h0003_0000);
    wr(`EFR_OFS_PORT_CTRL, 32'h4);
    for (int k = 0; k < 4; k++) send('{6'h0, 2'h0, 3'h0, 8'h0, 1'h0, 1'h0, 6'h0, 1'h0, 3'h0, 3'h0, 1'h0, 2'h0, 6'h0, 32'(k)});
    frm_valid_in <= 1'h0;
    wr(`EFR_OFS_PORT_CTRL, 32'h6);
    chk(64'(frm_ready_out), 64'h1);
    send(rows[1]);
    send(rows[2]);
    frm_valid_in <= 1'h0;
    rdc(`EFR_OFS_STATUS, 32'h0005_0004);
    wr(`EFR_OFS_PORT_CTRL, 32'h4);
    mac_stall <= 1'h0;
    repeat (12) @(posedge clock_in);
    chk(64'(u_mac.got.size()), 64'h4);
    for (int k = 0; k < 4; k++) begin
      get(d);
      chk(64'(d.residence), 64'(k));
    end
    results();
  end
endmodule
